// ==== itdx_defines.svh ====
/*
 * constants for the tail-of-set decoder and executor: field positions,
 * primary opcodes, sub-field codes and shadow bank sizes.
 * assumes it is included by the package and the design modules only.
 */
`ifndef ITDX_DEFINES_SVH
`define ITDX_DEFINES_SVH

// primary opcode halves
`define ITDX_ROW_HI      31
`define ITDX_ROW_LO      29
`define ITDX_COL_HI      28
`define ITDX_COL_LO      26

// primary opcodes
`define ITDX_OPC_SPECIAL 6'h00
`define ITDX_OPC_REG_IMMEDIATE_CLASS  6'h01
`define ITDX_OPC_XOR_IMMEDIATE_INSTR    6'h0e
`define ITDX_OPC_SYSTEM_COPROC_CLASS    6'h10
`define ITDX_OPC_COP1    6'h11
`define ITDX_OPC_COP2    6'h12
`define ITDX_OPC_DADDI   6'h18
`define ITDX_OPC_DADDIU  6'h19
`define ITDX_OPC_SPEC2   6'h1c
`define ITDX_OPC_ASE     6'h1e
`define ITDX_OPC_SPEC3   6'h1f

// function, sub-field and shift-amount codes
`define ITDX_FN_XOR      6'h26
`define ITDX_FN_WAIT     6'h20
`define ITDX_FN_DERET    6'h1f
`define ITDX_FN_SDBBP    6'h3f
`define ITDX_FN_BSHFL    6'h20
`define ITDX_S2_UDI_ROW  2'h1
`define ITDX_S3_RSV_LO   3'h1
`define ITDX_S3_RSV_HI   3'h3
`define ITDX_RS_PREVW    5'h0e
`define ITDX_RS_DMFC1    5'h01
`define ITDX_RS_DMTC1    5'h05
`define ITDX_FMT_L       5'h15
`define ITDX_RI_RSV_ROW  2'h3
`define ITDX_SA_ZERO     5'h00
`define ITDX_SA_WSBH     5'h02
`define ITDX_SA_SEB      5'h10
`define ITDX_SA_SEH      5'h18
`define ITDX_LOW11_ZERO  11'h000

// shadow bank geometry
`define ITDX_SETS        16
`define ITDX_REGS        32
`define ITDX_XLEN        64

`endif

// ==== itdx_pkg.sv ====
/*
 * types for the tail-of-set decoder: operation kinds, exception kinds
 * and the packed carriers between pipeline and decoder.
 * assumes itdx_defines.svh is reachable on the include path.
 */
`include "itdx_defines.svh"

package itdx_pkg;

  typedef enum logic [1:0] {
    EXC_NONE,
    EXC_RI,
    EXC_CPU
  } itdx_exc_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_XOR,
    OP_XOR_IMMEDIATE_INSTR,
    OP_WSBH,
    OP_PREVW,
    OP_WAIT
  } itdx_op_t;

  // instruction word with operands already read from the register file
  typedef struct packed {
    logic [31:0]            word;
    logic [`ITDX_XLEN-1:0]  rs_val;
    logic [`ITDX_XLEN-1:0]  rt_val;
  } itdx_req_t;

  // core configuration, steady while instructions are issued
  typedef struct packed {
    logic        release2;
    logic        kx64_en;
    logic        fp64_en;
    logic [2:0]  cu_ok;
    logic        dbg_impl;
    logic        ase_impl;
    logic        udi_impl;
    logic        cop2_impl;
    logic [3:0]  pss;
  } itdx_cfg_t;

  typedef struct packed {
    logic                   valid;
    logic                   handled;
    logic                   gpr_we;
    logic [4:0]             gpr_dst;
    logic [`ITDX_XLEN-1:0]  gpr_data;
    itdx_exc_t              exc;
    logic [1:0]             cop_num;
  } itdx_res_t;

  typedef struct packed {
    logic                   we;
    logic [3:0]             set;
    logic [4:0]             idx;
    logic [`ITDX_XLEN-1:0]  data;
  } itdx_shw_t;

endpackage

// ==== itdx_shadow_bank.sv ====
/*
 * shadow register sets: one synchronous write port, one registered
 * read port. assumes a single clock and that the writer never writes
 * and expects the new value on the read port in the same cycle.
 */
`timescale 1ns/1ns
`include "itdx_defines.svh"

module itdx_shadow_bank
  import itdx_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire itdx_shw_t             wr_i,
  input  wire logic [3:0]            rd_set_i,
  input  wire logic [4:0]            rd_idx_i,
  output logic      [`ITDX_XLEN-1:0] rd_data_o
);

  logic [`ITDX_XLEN-1:0] bank [`ITDX_SETS*`ITDX_REGS];
  logic [`ITDX_XLEN-1:0] next_rd_data;

  // storage has no reset; it is data, not control
  always_ff @(posedge sys_clk_i) begin
    if (wr_i.we) begin
      bank[{wr_i.set, wr_i.idx}] <= wr_i.data;
    end
  end

  // read data is registered so the port comes from flip-flops
  always_comb begin
    next_rd_data = bank[{rd_set_i, rd_idx_i}];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 64'h0000_0000_0000_0000;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule

// ==== itdx_decode_exec.sv ====
/*
 * decode and execute for the tail instructions and the primary opcode
 * scheme: standby, previous-shadow write, halfword byte swap, xor and
 * xor-immediate, plus exception classes of reserved and optional codes.
 * assumes the pipeline, interrupt logic and config all run on sys_clk_i.
 */
// Summary of operation
// - standby enters low power; pending interrupt taken before next instruction
// - previous-shadow write is coprocessor-0 class, source 01110, low eleven zero
// - previous-shadow write copies second operand into selected shadow register
// - previous-shadow write before second release raises reserved instruction
// - byte swap swaps bytes in each low halfword, sign-extends, writes destination
// - byte swap before second release raises reserved instruction
// - register xor writes rs xor rt, no exception
// - immediate xor zero-extends immediate, writes second operand register
// - primary opcode decoded first; class codes resolved from other fields
// - register-immediate opcode holds immediate branches and traps
// - primary opcode is bits 31..29 high, 28..26 low
// - a field class code is decoded further through another field
// - reserved codes raise reserved instruction
// - codes of higher level or newer revision raise reserved instruction
// - 64-bit-only codes need 64-bit enable, else reserved or unusable
// - 64-bit float class needs 64-bit float enable under second release
// - unused licensee codes raise reserved, or unusable without access
// - omitted debug encodings raise reserved instruction
// - unimplemented extension codes raise reserved instruction
// - second-release codes execute there; first release raises reserved
// - standby raises coprocessor unusable without system coprocessor access
`timescale 1ns/1ns
`include "itdx_defines.svh"

module itdx_decode_exec
  import itdx_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  instr_valid_i,
  output logic                       instr_ready_o,
  input  wire itdx_req_t             req_i,
  input  wire itdx_cfg_t             cfg_i,
  input  wire logic                  irq_pending_i,
  input  wire logic                  wake_i,
  input  wire logic [3:0]            sh_rd_set_i,
  input  wire logic [4:0]            sh_rd_idx_i,
  output logic      [`ITDX_XLEN-1:0] sh_rd_data_o,
  output itdx_res_t                  res_o,
  output logic                       standby_o,
  output logic                       irq_take_o
);

  typedef enum logic {ST_RUN, ST_STANDBY} itdx_state_t;

  itdx_state_t st, next_st;
  logic        next_irq_take;
  itdx_res_t   next_res;
  itdx_shw_t   shw, next_shw;
  itdx_op_t    d_op;
  itdx_exc_t   d_exc;
  logic [1:0]  d_cop;
  logic [5:0]  opc;
  logic [4:0]  rs_f, rt_f, rd_f, sa_f;
  logic [5:0]  fn_f;
  logic        accept;
  logic        ok;

  // coprocessor codes fault differently depending on access rights
  function automatic itdx_exc_t cop_fault(input logic access_ok);
    cop_fault = access_ok ? EXC_RI : EXC_CPU;
  endfunction

  // bytes swapped within each halfword of the low word, then sign-extended
  function automatic logic [`ITDX_XLEN-1:0] swap_halves(input logic [`ITDX_XLEN-1:0] v);
    swap_halves = {{32{v[23]}}, v[23:16], v[31:24], v[7:0], v[15:8]};
  endfunction

  // field split of the instruction word
  // opcode halves joined
  assign opc  = {req_i.word[`ITDX_ROW_HI:`ITDX_ROW_LO], req_i.word[`ITDX_COL_HI:`ITDX_COL_LO]};
  assign rs_f = req_i.word[25:21];
  assign rt_f = req_i.word[20:16];
  assign rd_f = req_i.word[15:11];
  assign sa_f = req_i.word[10:6];
  assign fn_f = req_i.word[5:0];

  // the pipeline is held off while the core sits in standby
  assign instr_ready_o = (st == ST_RUN);
  assign accept        = instr_valid_i && instr_ready_o;
  assign ok            = (d_exc == EXC_NONE);

  // primary decode; codes outside this block's set fall through unhandled
  always_comb begin
    d_op  = OP_NONE;
    d_exc = EXC_NONE;
    d_cop = 2'h0;
    unique case (opc)
      `ITDX_OPC_SPECIAL: begin
        if (fn_f == `ITDX_FN_XOR && sa_f == `ITDX_SA_ZERO) begin
          d_op = OP_XOR;
        end
      end
      `ITDX_OPC_REG_IMMEDIATE_CLASS: begin
        if (rt_f[4:3] == `ITDX_RI_RSV_ROW) begin
          d_exc = EXC_RI;
        end
      end
      `ITDX_OPC_XOR_IMMEDIATE_INSTR: begin
        d_op = OP_XOR_IMMEDIATE_INSTR;
      end
      `ITDX_OPC_SYSTEM_COPROC_CLASS: begin
        d_cop = 2'h0;
        if (!cfg_i.cu_ok[0]) begin
          d_exc = EXC_CPU;
        end else if (rs_f[4]) begin
          if (fn_f == `ITDX_FN_WAIT) begin
            d_op = OP_WAIT;
          end else if (fn_f == `ITDX_FN_DERET && !cfg_i.dbg_impl) begin
            d_exc = EXC_RI;
          end
        end else if (rs_f == `ITDX_RS_PREVW && req_i.word[10:0] == `ITDX_LOW11_ZERO) begin
          if (cfg_i.release2) begin
            d_op = OP_PREVW;
          end else begin
            d_exc = EXC_RI;
          end
        end
      end
      `ITDX_OPC_COP1: begin
        d_cop = 2'h1;
        if ((rs_f == `ITDX_RS_DMFC1 || rs_f == `ITDX_RS_DMTC1) && !cfg_i.kx64_en) begin
          d_exc = cop_fault(cfg_i.cu_ok[1]);
        end
        if (rs_f == `ITDX_FMT_L &&
            !(cfg_i.release2 ? cfg_i.fp64_en : cfg_i.kx64_en)) begin
          d_exc = cop_fault(cfg_i.cu_ok[1]);
        end
      end
      `ITDX_OPC_COP2: begin
        d_cop = 2'h2;
        if (!cfg_i.cop2_impl) begin
          d_exc = cop_fault(cfg_i.cu_ok[2]);
        end
      end
      `ITDX_OPC_DADDI,
      `ITDX_OPC_DADDIU: begin
        if (!cfg_i.kx64_en) begin
          d_exc = EXC_RI;
        end
      end
      `ITDX_OPC_SPEC2: begin
        if (fn_f[5:4] == `ITDX_S2_UDI_ROW && !cfg_i.udi_impl) begin
          d_exc = EXC_RI;
        end
        if (fn_f == `ITDX_FN_SDBBP && !cfg_i.dbg_impl) begin
          d_exc = EXC_RI;
        end
      end
      `ITDX_OPC_ASE: begin
        if (!cfg_i.ase_impl) begin
          d_exc = EXC_RI;
        end
      end
      `ITDX_OPC_SPEC3: begin
        if (!cfg_i.release2) begin
          d_exc = EXC_RI;
        end else if (fn_f == `ITDX_FN_BSHFL) begin
          if (sa_f == `ITDX_SA_WSBH) begin
            d_op = OP_WSBH;
          end else if (sa_f != `ITDX_SA_SEB && sa_f != `ITDX_SA_SEH) begin
            d_exc = EXC_RI;
          end
        end else if (fn_f[5:3] >= `ITDX_S3_RSV_LO && fn_f[5:3] <= `ITDX_S3_RSV_HI) begin
          d_exc = EXC_RI;
        end
      end
      default: begin
      end
    endcase
  end

  // result stage: one registered answer per accepted instruction
  always_comb begin
    next_res          = '0;
    next_res.valid    = accept;
    next_res.handled  = accept && (d_op != OP_NONE || !ok);
    next_res.exc      = accept ? d_exc : EXC_NONE;
    next_res.cop_num  = d_cop;
    if (accept && ok) begin
      unique case (d_op)
        OP_XOR: begin
          next_res.gpr_we   = 1'b1;
          next_res.gpr_dst  = rd_f;
          next_res.gpr_data = req_i.rs_val ^ req_i.rt_val;
        end
        OP_XOR_IMMEDIATE_INSTR: begin
          next_res.gpr_we   = 1'b1;
          next_res.gpr_dst  = rt_f;
          next_res.gpr_data = req_i.rs_val ^ {48'h0000_0000_0000, req_i.word[15:0]};
        end
        OP_WSBH: begin
          // swap and sign-extend; upper source bits ignored
          next_res.gpr_we   = 1'b1;
          next_res.gpr_dst  = rd_f;
          next_res.gpr_data = swap_halves(req_i.rt_val);
        end
        OP_NONE,
        OP_PREVW,
        OP_WAIT: begin
        end
      endcase
    end
  end

  // shadow write is staged one cycle so it lines up with the result
  always_comb begin
    next_shw      = '0;
    // copy rt into shadow set and index
    next_shw.we   = accept && ok && (d_op == OP_PREVW);
    next_shw.set  = cfg_i.pss;
    next_shw.idx  = rd_f;
    next_shw.data = req_i.rt_val;
  end

  // standby machine; irq take is flagged on the exit cycle
  always_comb begin
    next_st       = st;
    next_irq_take = 1'b0;
    unique case (st)
      ST_RUN: begin
        if (accept && ok && d_op == OP_WAIT) begin
          next_st = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        // wake and take interrupt at boundary
        if (irq_pending_i || wake_i) begin
          next_st       = ST_RUN;
          next_irq_take = irq_pending_i;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st         <= ST_RUN;
      irq_take_o <= 1'b0;
      res_o      <= '0;
      shw        <= '0;
    end else begin
      st         <= next_st;
      irq_take_o <= next_irq_take;
      res_o      <= next_res;
      shw        <= next_shw;
    end
  end

  assign standby_o = (st == ST_STANDBY);

  itdx_shadow_bank u_bank (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .wr_i      (shw),
    .rd_set_i  (sh_rd_set_i),
    .rd_idx_i  (sh_rd_idx_i),
    .rd_data_o (sh_rd_data_o)
  );

  // checks of the decoded behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_wait_go;
    accept && ok && d_op == OP_WAIT;
  endsequence

  sequence s_wake_irq;
    standby_o && irq_pending_i;
  endsequence

  a_wait_enters_standby: assert property (s_wait_go |=> standby_o && !instr_ready_o)
    else $error("standby not entered after wait");

  a_irq_at_boundary: assert property (s_wake_irq |=> irq_take_o && instr_ready_o ##1 !irq_take_o)
    else $error("interrupt not taken at wake boundary");

  a_wait_no_access: assert property (accept && opc == `ITDX_OPC_SYSTEM_COPROC_CLASS && !cfg_i.cu_ok[0]
    |=> res_o.exc == EXC_CPU && !standby_o)
    else $error("system_coproc_class access fault missing");

  a_prevw_old_rel: assert property (accept && opc == `ITDX_OPC_SYSTEM_COPROC_CLASS && cfg_i.cu_ok[0]
    && rs_f == `ITDX_RS_PREVW && req_i.word[10:0] == `ITDX_LOW11_ZERO && !cfg_i.release2
    |=> res_o.exc == EXC_RI && !shw.we)
    else $error("shadow write not refused on first release");

  // a back-to-back second shadow write is legal, so only a stray write fails the tail
  a_shadow_copy: assert property (accept && ok && d_op == OP_PREVW
    |=> shw.we && shw.data == $past(req_i.rt_val) && shw.idx == $past(rd_f)
        && shw.set == $past(cfg_i.pss)
        ##1 (!shw.we || $past(accept && ok && d_op == OP_PREVW)))
    else $error("shadow copy wrong");

  a_xor_result: assert property (accept && opc == `ITDX_OPC_SPECIAL
    && fn_f == `ITDX_FN_XOR && sa_f == `ITDX_SA_ZERO
    |=> res_o.gpr_we && res_o.exc == EXC_NONE
        && res_o.gpr_data == ($past(req_i.rs_val) ^ $past(req_i.rt_val)))
    else $error("register xor result wrong");

  a_xor_immediate_instr_result: assert property (accept && opc == `ITDX_OPC_XOR_IMMEDIATE_INSTR
    |=> res_o.gpr_we && res_o.gpr_dst == $past(rt_f) && res_o.gpr_data[63:16]
        == $past(req_i.rs_val[63:16]))
    else $error("immediate xor result wrong");

  a_wsbh_result: assert property (accept && ok && d_op == OP_WSBH
    |=> res_o.gpr_data[15:0] == {$past(req_i.rt_val[7:0]), $past(req_i.rt_val[15:8])}
        && res_o.gpr_data[63:32] == {32{res_o.gpr_data[31]}})
    else $error("byte swap result wrong");

  a_wsbh_old_rel: assert property (accept && opc == `ITDX_OPC_SPEC3 && !cfg_i.release2
    |=> res_o.exc == EXC_RI && !res_o.gpr_we)
    else $error("second-release code not refused");

  a_dword_gate: assert property (accept && opc == `ITDX_OPC_DADDI && !cfg_i.kx64_en
    |=> res_o.exc == EXC_RI)
    else $error("64-bit code not refused");

  a_result_pulse: assert property (res_o.valid == $past(accept))
    else $error("result valid not tied to an accepted instruction");

endmodule

// ==== itdx_pipe_model.sv ====
/*
 * pipeline stand-in: offers one instruction word with its operands and
 * holds it until the decoder takes it.
 * assumes the bench raises issue_i only while no word is outstanding.
 */
`timescale 1ns/1ns

module itdx_pipe_model
  import itdx_pkg::*;
(
  input  wire logic      sys_clk_i,
  input  wire logic      arst_n_i,
  input  wire logic      issue_i,
  input  wire itdx_req_t next_req_i,
  input  wire logic      instr_ready_i,
  output logic           instr_valid_o,
  output itdx_req_t      req_o
);
  logic      next_valid;
  itdx_req_t next_req;

  // hold the word until taken; afterwards show its inverse so a stale word never matches
  always_comb begin
    next_valid = instr_valid_o;
    next_req   = req_o;
    if (issue_i) begin
      next_valid = 1'h1;
      next_req   = next_req_i;
    end else if (instr_valid_o && instr_ready_i) begin
      next_valid = 1'h0;
      next_req   = ~req_o;
    end
  end

  // offer register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_valid_o <= 1'h0;
      req_o         <= '0;
    end else begin
      instr_valid_o <= next_valid;
      req_o         <= next_req;
    end
  end
endmodule

// ==== isa_tail_decode_exec_test.sv ====
/*
 * self-checking bench for the tail-of-set decoder: random and corner words
 * go through the pipeline model, results are compared with values worked out here.
 * assumes the package, the design and the pipeline model are compiled first.
 */
`timescale 1ns/1ns
`define ITDX_CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected at %0t: got %h want %h", $time, got, exp); \
    end \
  end

module isa_tail_decode_exec_test
  import itdx_pkg::*;
;
  logic        sys_clk_i, arst_n_i, issue, instr_valid, instr_ready;
  logic        irq_pending, wake, standby, irq_take;
  logic [3:0]  rd_set;
  logic [4:0]  rd_idx;
  logic [63:0] rd_data, a, b;
  logic [31:0] w;
  itdx_req_t   next_req, req;
  itdx_cfg_t   cfg, base;
  itdx_res_t   res, got;
  int          fails, tests_run, takes;
  localparam logic [31:0] WAIT_W = {6'h10, 1'h1, 19'h0_0000, 6'h20};

  itdx_pipe_model pipe_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .issue_i(issue),
    .next_req_i(next_req), .instr_ready_i(instr_ready), .instr_valid_o(instr_valid),
    .req_o(req));

  itdx_decode_exec dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid), .instr_ready_o(instr_ready), .req_i(req), .cfg_i(cfg),
    .irq_pending_i(irq_pending), .wake_i(wake), .sh_rd_set_i(rd_set), .sh_rd_idx_i(rd_idx),
    .sh_rd_data_o(rd_data), .res_o(res), .standby_o(standby), .irq_take_o(irq_take));

  initial begin
    sys_clk_i = 1'h0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // count interrupt hand-offs so a wake without interrupt can be told apart
  always @(posedge sys_clk_i) begin
    if (irq_take === 1'h1) begin
      takes++;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic itdx_cfg_t mk_cfg(logic r2, logic k64, logic f64, logic [2:0] cu,
                                       logic [3:0] imp);
    return '{r2, k64, f64, cu, imp[3], imp[2], imp[1], imp[0], cfg.pss};
  endfunction

  function automatic logic [63:0] swap_exp(logic [63:0] v);
    logic [31:0] h;
    h = {v[23:16], v[31:24], v[7:0], v[15:8]};
    return {{32{h[31]}}, h};
  endfunction

  // offer one word, wait (bounded) while refused, capture the answer one cycle after taking
  task automatic run(input logic [31:0] iw, input logic [63:0] rs, input logic [63:0] rt);
    int n;
    @(posedge sys_clk_i);
    #1;
    issue = 1'h1;
    next_req = '{iw, rs, rt};
    @(posedge sys_clk_i);
    #1;
    issue = 1'h0;
    n = 0;
    while (instr_ready !== 1'h1 && n < 50) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (instr_ready !== 1'h1) begin
      fails++;
      tally_and_finish();
    end
    @(posedge sys_clk_i);
    #1;
    got = res;
  endtask

  task automatic chk_res(input logic we, input logic [4:0] dst, input logic [63:0] d,
                         input itdx_exc_t e);
    `ITDX_CHK(got.valid, 1'h1)
    `ITDX_CHK(got.gpr_we, we)
    `ITDX_CHK(got.exc, e)
    if (we) begin
      `ITDX_CHK(got.gpr_dst, dst)
      `ITDX_CHK(got.gpr_data, d)
    end
  endtask

  task automatic chk_exc(input logic [31:0] iw, input itdx_cfg_t c, input itdx_exc_t e,
                         input logic [1:0] cop);
    cfg = c;
    run(iw, {$urandom(), $urandom()}, {$urandom(), $urandom()});
    chk_res(1'h0, 5'h00, 64'h0, e);
    if (e == EXC_CPU) begin
      `ITDX_CHK(got.cop_num, cop)
    end
  endtask

  initial begin
    arst_n_i = 1'h0;
    issue = 1'h0;
    next_req = '0;
    irq_pending = 1'h0;
    wake = 1'h0;
    rd_set = 4'h0;
    rd_idx = 5'h00;
    fails = 0;
    tests_run = 0;
    takes = 0;
    base = '{1'h1, 1'h1, 1'h1, 3'h7, 1'h1, 1'h1, 1'h1, 1'h1, 4'h0};
    cfg = base;
    void'($urandom(32'h0eaf2963));
    repeat (16) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'h1;
    `ITDX_CHK(standby, 1'h0)
    // xor against register and zero-extended immediate, alternating words
    for (int i = 0; i < 24; i++) begin
      a = {$urandom(), $urandom()};
      b = {$urandom(), $urandom()};
      w = $urandom();
      run({6'h00, w[25:11], 5'h00, 6'h26}, a, b);
      chk_res(1'h1, w[15:11], a ^ b, EXC_NONE);
      run({6'h0e, w[25:0]}, a, b);
      chk_res(1'h1, w[20:16], a ^ {48'h0, w[15:0]}, EXC_NONE);
    end
    $display("test xor done");
    // byte swap; the source is kept sign-extended as software must
    for (int i = 0; i < 8; i++) begin
      w = $urandom();
      b = {{32{w[31]}}, w};
      run({6'h1f, 5'h00, w[20:16], w[15:11], 5'h02, 6'h20}, {$urandom(), $urandom()}, b);
      chk_res(1'h1, w[15:11], swap_exp(b), EXC_NONE);
    end
    chk_exc({6'h1f, 15'h0, 5'h02, 6'h20}, mk_cfg(1'h0, 1'h1, 1'h1, 3'h7, 4'hf), EXC_RI, 2'h0);
    $display("test byte swap done");
    // previous-shadow write, then read back through the shadow port
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      b = {$urandom(), $urandom()};
      cfg = base;
      cfg.pss = w[3:0];
      run({6'h10, 5'h0e, w[20:16], w[15:11], 11'h000}, {$urandom(), $urandom()}, b);
      chk_res(1'h0, 5'h00, 64'h0, EXC_NONE);
      `ITDX_CHK(got.handled, 1'h1)
      @(posedge sys_clk_i);
      #1;
      rd_set = w[3:0];
      rd_idx = w[15:11];
      @(posedge sys_clk_i);
      #1;
      `ITDX_CHK(rd_data, b)
    end
    chk_exc({6'h10, 5'h0e, 10'h000, 11'h001}, base, EXC_NONE, 2'h0);
    `ITDX_CHK(got.handled, 1'h0)
    chk_exc({6'h10, 5'h0e, 21'h0}, mk_cfg(1'h0, 1'h1, 1'h1, 3'h7, 4'hf), EXC_RI, 2'h0);
    $display("test shadow write done");
    // standby left by an interrupt, then by a wake with a word waiting
    cfg = base;
    run(WAIT_W, 64'h0, 64'h0);
    chk_res(1'h0, 5'h00, 64'h0, EXC_NONE);
    `ITDX_CHK(standby, 1'h1)
    `ITDX_CHK(instr_ready, 1'h0)
    irq_pending = 1'h1;
    @(posedge sys_clk_i);
    #1;
    `ITDX_CHK(standby, 1'h0)
    `ITDX_CHK(irq_take, 1'h1)
    irq_pending = 1'h0;
    run(WAIT_W, 64'h0, 64'h0);
    fork
      begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        wake = 1'h1;
        @(posedge sys_clk_i);
        #1;
        wake = 1'h0;
      end
    join_none
    run({6'h00, 5'h01, 5'h02, 5'h03, 5'h00, 6'h26}, a, b);
    chk_res(1'h1, 5'h03, a ^ b, EXC_NONE);
    `ITDX_CHK(takes, 1)
    chk_exc(WAIT_W, mk_cfg(1'h1, 1'h1, 1'h1, 3'h6, 4'hf), EXC_CPU, 2'h0);
    `ITDX_CHK(standby, 1'h0)
    $display("test standby done");
    // classes, reserved and optional codes
    chk_exc({6'h01, 5'h00, 5'h18, 16'h0}, base, EXC_RI, 2'h0);
    chk_exc({6'h01, 5'h00, 5'h00, 16'h0}, base, EXC_NONE, 2'h0);
    chk_exc({6'h31, 26'h0}, base, EXC_NONE, 2'h0);
    `ITDX_CHK(got.handled, 1'h0)
    chk_exc({6'h18, 26'h0}, mk_cfg(1'h1, 1'h0, 1'h1, 3'h7, 4'hf), EXC_RI, 2'h0);
    chk_exc({6'h19, 26'h0}, base, EXC_NONE, 2'h0);
    chk_exc({6'h11, 5'h01, 21'h0}, mk_cfg(1'h1, 1'h0, 1'h1, 3'h7, 4'hf), EXC_RI, 2'h0);
    chk_exc({6'h11, 5'h05, 21'h0}, mk_cfg(1'h1, 1'h0, 1'h1, 3'h5, 4'hf), EXC_CPU, 2'h1);
    chk_exc({6'h11, 5'h15, 21'h0}, mk_cfg(1'h1, 1'h1, 1'h0, 3'h7, 4'hf), EXC_RI, 2'h0);
    chk_exc({6'h11, 5'h15, 21'h0}, base, EXC_NONE, 2'h0);
    chk_exc({6'h12, 26'h0}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h7, 4'he), EXC_RI, 2'h0);
    chk_exc({6'h12, 26'h0}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h3, 4'he), EXC_CPU, 2'h2);
    chk_exc({6'h1c, 20'h0, 6'h10}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h7, 4'hd), EXC_RI, 2'h0);
    chk_exc({6'h1c, 20'h0, 6'h3f}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h7, 4'h7), EXC_RI, 2'h0);
    chk_exc({6'h10, 1'h1, 19'h0, 6'h1f}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h7, 4'h7), EXC_RI, 2'h0);
    chk_exc({6'h1e, 26'h0}, mk_cfg(1'h1, 1'h1, 1'h1, 3'h7, 4'hb), EXC_RI, 2'h0);
    chk_exc({6'h1f, 20'h0, 6'h08}, base, EXC_RI, 2'h0);
    chk_exc({6'h1f, 15'h0, 5'h03, 6'h20}, base, EXC_RI, 2'h0);
    chk_exc({6'h1f, 20'h0, 6'h00}, mk_cfg(1'h0, 1'h1, 1'h1, 3'h7, 4'hf), EXC_RI, 2'h0);
    chk_exc({6'h10, 5'h0e, 21'h0}, base, EXC_NONE, 2'h0);
    $display("test classes done");
    tally_and_finish();
  end
endmodule
